// ---- rtl/nvw_top.sv ----
// Write-only two-wire serial slave steering a 32-position wiper.
// Assumes SCL and SDA are asynchronous pins; master owns the clock.
`timescale 1ns/1ps
`default_nettype none
`include "nvw_map.svh"
////////////////////////////////////////////////////////////////////////////////
// Function
// (RQ1) Wiper holds one of 32 taps
// (RQ2) Live write moves wiper, stored write keeps
// (RQ3) Stored write busy for 12 ms
// (RQ4) Live clears on power loss, stored keeps
// (RQ5) Power-up copies stored into live
// (RQ6) Shift, decode, steer data byte
// (RQ7) Master starts transfers and makes clock
// (RQ8) Data open-drain, clock input only
// (RQ9) START, address, command, data, STOP
// (RQ10) Both lines high means idle
// (RQ11) SDA fall with SCL high starts
// (RQ12) SDA rise with SCL high stops
// (RQ13) One bit per clock, stable high
// (RQ14) Acknowledge each byte, low in ninth; data bytes after the first one go unacked
// (RQ15) Master gives nine clocks, releases ack
// (RQ16) Eighth bit zero writes, one skips
// (RQ17) Address top nibble is 0101
// (RQ18) Select pin sets address bit zero
// (RQ19) Resistor variant address fully fixed
// (RQ20) System gives each device unique address
// (RQ21) Wiper from data bits seven to three
// (RQ22) Four command codes decoded
// (RQ23) Stored register five bits, zero shipped
// (RQ24) Power-up recall within 20 us
// (RQ25) Mismatched address ignored, no ack
// (RQ26) Skip bit leaves registers unchanged
module nvw_top #(
  parameter logic FACT_HIGH = 1'b0, // Factory high address bit
  parameter logic FACT_MID = 1'b0, // Factory mid address bit
  parameter logic FACT_LOW = 1'b0, // Factory low bit, two-terminal variant
  parameter logic USE_SELECT_PIN = 1'b1, // 1: three-terminal, pin sets bit zero
  parameter int STORE_CYC = `NVW_STORE_CYC, // Store busy cycles
  parameter int INIT_CYC = `NVW_INIT_CYC // Power-up recall cycles
) (
  input wire logic CLK, // 50 MHz clock
  input wire logic NRST, // Async reset, active low
  input wire logic SCL, // Serial clock pin
  input wire logic SDA_I, // Serial data pin level
  output logic SDA_O, // Serial data drive value
  output logic SDA_OE_N, // Low while pulling SDA
  input wire logic ADDRESS_SELECT_PIN, // Address bit zero strap
  output nvw_pkg::nvw_wiper_type WIPER, // Live wiper position
  output nvw_pkg::nvw_wiper_type STORED, // Stored position
  output logic BUSY, // Store programming in progress
  output logic INIT_DONE // Power-up recall done
);
  import nvw_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // Pin sampling
  logic scl_s, sda_s, sel_s;
  logic scl_q, sda_q;
  nvw_sync u_scl (.clk(CLK), .nrst(NRST), .din(SCL), .dout(scl_s)); // RQ8
  nvw_sync u_sda (.clk(CLK), .nrst(NRST), .din(SDA_I), .dout(sda_s));
  nvw_sync u_sel (.clk(CLK), .nrst(NRST), .din(ADDRESS_SELECT_PIN), .dout(sel_s));
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end
  wire scl_rise = scl_s && !scl_q; // RQ13
  wire scl_fall = !scl_s && scl_q;
  wire start_det = scl_s && scl_q && sda_q && !sda_s; // RQ11
  wire stop_det = scl_s && scl_q && !sda_q && sda_s; // RQ12
  ////////////////////////////////////////////////////////////////////////////////
  // Address match
  wire addr_bit0 = USE_SELECT_PIN ? sel_s : FACT_LOW; // RQ18 RQ19
  wire [6:0] own_addr = {`NVW_ADDR_TOP, FACT_HIGH, FACT_MID, addr_bit0}; // RQ17
  ////////////////////////////////////////////////////////////////////////////////
  // Byte engine
  nvw_state_type state_q, state_d;
  logic [7:0] shift_q;
  logic [3:0] bit_q;
  logic [7:0] cmd_q;
  logic skip_q;
  logic ack_q;
  logic written_q;
  wire [7:0] shift_next = {shift_q[6:0], sda_s};
  wire byte_done = scl_rise && bit_q == 4'h7;
  wire ack_slot = bit_q == 4'h8;
  // Ninth clock: counted so that the ack bit is never shifted in as data
  wire ack_end = bit_q == 4'h9;
  wire addr_ok = shift_next[7:1] == own_addr;
  nvw_cmd_if cmd_bus();
  always_comb begin
    state_d = state_q;
    case (state_q)
      NVW_IDLE: state_d = NVW_IDLE;
      NVW_ADDR: if (byte_done) state_d = addr_ok ? NVW_CMD : NVW_SKIP; // RQ25
      NVW_CMD: if (byte_done) state_d = NVW_DATA; // RQ9
      NVW_DATA: if (byte_done && written_q) state_d = NVW_SKIP;
      NVW_SKIP: state_d = NVW_SKIP;
      default: state_d = NVW_IDLE;
    endcase
    if (start_det) state_d = NVW_ADDR; // RQ11
    else if (stop_det) state_d = NVW_IDLE; // RQ12 RQ10
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= NVW_IDLE;
      bit_q <= '0;
      shift_q <= '0;
    end else begin
      state_q <= state_d;
      if (start_det) bit_q <= '0;
      else if (scl_fall && ack_end) bit_q <= '0; // RQ15
      else if (scl_rise && !ack_end) bit_q <= bit_q + 4'h1; // RQ13
      if (scl_rise && bit_q < 4'h8) shift_q <= shift_next; // RQ6
    end
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cmd_q <= '0;
      skip_q <= 1'b0;
      written_q <= 1'b0;
    end else begin
      if (start_det) written_q <= 1'b0;
      if (byte_done && state_q == NVW_ADDR) skip_q <= shift_next[0]; // RQ16
      if (byte_done && state_q == NVW_CMD) cmd_q <= shift_next; // RQ6
      if (byte_done && state_q == NVW_DATA) written_q <= 1'b1;
    end
  end
  // Only the first data byte after the command counts; later bytes are not acked
  wire data_take = byte_done && state_q == NVW_DATA && !written_q && !skip_q; // RQ26
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cmd_bus.valid <= 1'b0;
      cmd_bus.cmd <= '0;
      cmd_bus.data <= '0;
    end else begin
      cmd_bus.valid <= data_take; // RQ6
      if (data_take) begin
        cmd_bus.cmd <= cmd_q; // RQ22
        cmd_bus.data <= shift_next[7:3]; // RQ21
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Match is evaluated on the rise of bit eight; remember it for the ack fall
  logic match_q;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) match_q <= 1'b0;
    else if (byte_done) match_q <= state_q != NVW_ADDR || addr_ok;
  end
  // Acknowledge drive: set on the fall ending bit eight, held across the ninth clock
  wire ack_want = match_q && (state_q == NVW_CMD || state_q == NVW_DATA); // RQ25
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) ack_q <= 1'b0;
    else if (start_det || stop_det) ack_q <= 1'b0;
    else if (scl_fall && bit_q == 4'h8 && !ack_q && ack_want) ack_q <= 1'b1; // RQ14
    else if (scl_fall && ack_q) ack_q <= 1'b0;
  end
  assign SDA_O = 1'b0; // RQ8
  assign SDA_OE_N = !ack_q; // RQ8
  nvw_store #(.STORE_CYC(STORE_CYC), .INIT_CYC(INIT_CYC)) u_store (
    .clk(CLK),
    .nrst(NRST),
    .cmd_in(cmd_bus),
    .wiper(WIPER),
    .stored(STORED),
    .busy(BUSY),
    .init_done(INIT_DONE)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_ack_fall;
    scl_fall && bit_q == 4'h8 && !ack_q && ack_want;
  endsequence
  sequence s_ack_up;
    !SDA_OE_N && !scl_fall && !start_det && !stop_det;
  endsequence
  sequence s_addr_hit;
    byte_done && state_q == NVW_ADDR && addr_ok;
  endsequence
  sequence s_cmd_end;
    byte_done && state_q == NVW_CMD;
  endsequence
  // Hold is checked a cycle at a time; the master model samples both ends of the high time
  property p_ack_hold;
    @(posedge CLK) disable iff (!NRST)
    s_ack_fall |=> !SDA_OE_N;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack not driven"); // RQ14
  property p_ack_keep;
    @(posedge CLK) disable iff (!NRST)
    s_ack_up |=> !SDA_OE_N;
  endproperty
  a_ack_keep: assert property (p_ack_keep) else $error("ack released early"); // RQ14
  property p_no_ack_mismatch;
    @(posedge CLK) disable iff (!NRST)
    (byte_done && state_q == NVW_ADDR && !addr_ok) |=> (SDA_OE_N [*4]);
  endproperty
  a_no_ack_mismatch: assert property (p_no_ack_mismatch) else $error("acked foreign addr"); // RQ25
  property p_start_state;
    @(posedge CLK) disable iff (!NRST) start_det |=> state_q == NVW_ADDR && bit_q == 4'h0;
  endproperty
  a_start_state: assert property (p_start_state) else $error("start missed"); // RQ11
  property p_stop_idle;
    @(posedge CLK) disable iff (!NRST) (stop_det && !start_det) |=> state_q == NVW_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop missed"); // RQ12
  property p_skip_quiet;
    @(posedge CLK) disable iff (!NRST) (skip_q && state_q == NVW_DATA) |=> !cmd_bus.valid;
  endproperty
  a_skip_quiet: assert property (p_skip_quiet) else $error("skip wrote"); // RQ26
  property p_data_field;
    @(posedge CLK) disable iff (!NRST)
    data_take |=> cmd_bus.valid && cmd_bus.data == $past(shift_next[7:3]);
  endproperty
  a_data_field: assert property (p_data_field) else $error("data field wrong"); // RQ21
  property p_idle_release;
    @(posedge CLK) disable iff (!NRST) state_q == NVW_IDLE |-> SDA_OE_N;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("drive while idle"); // RQ10
  property p_drive_low;
    @(posedge CLK) disable iff (!NRST) !SDA_OE_N |-> !SDA_O;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("drove high"); // RQ8
  ////////////////////////////////////////////////////////////////////////////////
  // Bit counting and acknowledge slot
  property p_ack_drop;
    @(posedge CLK) disable iff (!NRST)
    (!SDA_OE_N && scl_fall) |=> SDA_OE_N;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held too long"); // RQ14
  property p_ack_start;
    @(posedge CLK) disable iff (!NRST)
    $fell(SDA_OE_N) |-> bit_q == 4'h8 && !scl_s;
  endproperty
  a_ack_start: assert property (p_ack_start) else $error("ack outside slot"); // RQ14
  property p_ack_at_rise;
    @(posedge CLK) disable iff (!NRST)
    (scl_rise && bit_q == 4'h8) |-> SDA_OE_N == !ack_want;
  endproperty
  a_ack_at_rise: assert property (p_ack_at_rise) else $error("ack level wrong"); // RQ14 RQ25
  property p_bit_bound;
    @(posedge CLK) disable iff (!NRST)
    bit_q < 4'hA;
  endproperty
  a_bit_bound: assert property (p_bit_bound) else $error("bit count overrun"); // RQ15
  property p_bit_step;
    @(posedge CLK) disable iff (!NRST)
    (scl_rise && bit_q < 4'h9) |=> bit_q == $past(bit_q) + 4'h1;
  endproperty
  a_bit_step: assert property (p_bit_step) else $error("clock not counted"); // RQ13
  property p_bit_wrap;
    @(posedge CLK) disable iff (!NRST)
    (scl_fall && bit_q == 4'h9) |=> bit_q == 4'h0;
  endproperty
  a_bit_wrap: assert property (p_bit_wrap) else $error("byte frame not restarted"); // RQ15
  property p_shift_in;
    @(posedge CLK) disable iff (!NRST)
    (scl_rise && bit_q < 4'h8) |=> shift_q == $past(shift_next);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("bit not shifted"); // RQ6 RQ13
  property p_ack_no_shift;
    @(posedge CLK) disable iff (!NRST)
    (scl_rise && bit_q == 4'h8) |=> $stable(shift_q);
  endproperty
  a_ack_no_shift: assert property (p_ack_no_shift) else $error("ack bit shifted"); // RQ15
  ////////////////////////////////////////////////////////////////////////////////
  // Frame order and decoding
  property p_addr_to_cmd;
    @(posedge CLK) disable iff (!NRST)
    s_addr_hit |=> state_q == NVW_CMD;
  endproperty
  a_addr_to_cmd: assert property (p_addr_to_cmd) else $error("own address dropped"); // RQ17
  property p_cmd_latch;
    @(posedge CLK) disable iff (!NRST)
    s_cmd_end |=> state_q == NVW_DATA && cmd_q == $past(shift_next);
  endproperty
  a_cmd_latch: assert property (p_cmd_latch) else $error("command not taken"); // RQ22 RQ9
  property p_skip_latch;
    @(posedge CLK) disable iff (!NRST)
    (byte_done && state_q == NVW_ADDR) |=> skip_q == $past(shift_next[0]);
  endproperty
  a_skip_latch: assert property (p_skip_latch) else $error("skip bit lost"); // RQ16
  property p_top_nibble;
    @(posedge CLK) disable iff (!NRST)
    (byte_done && state_q == NVW_ADDR && shift_next[7:4] != 4'h5) |=> state_q == NVW_SKIP;
  endproperty
  a_top_nibble: assert property (p_top_nibble) else $error("foreign nibble taken"); // RQ17
  property p_low_bit;
    @(posedge CLK) disable iff (!NRST)
    (byte_done && state_q == NVW_ADDR && shift_next[1] != addr_bit0) |=> state_q == NVW_SKIP;
  endproperty
  a_low_bit: assert property (p_low_bit) else $error("address bit zero ignored"); // RQ18 RQ19
  property p_one_data;
    @(posedge CLK) disable iff (!NRST)
    (byte_done && state_q == NVW_DATA && written_q) |=> state_q == NVW_SKIP;
  endproperty
  a_one_data: assert property (p_one_data) else $error("extra data byte taken"); // RQ9
  property p_written;
    @(posedge CLK) disable iff (!NRST)
    data_take |=> written_q;
  endproperty
  a_written: assert property (p_written) else $error("data byte not marked"); // RQ9
  property p_valid_pulse;
    @(posedge CLK) disable iff (!NRST)
    cmd_bus.valid |=> !cmd_bus.valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("write pulse too long"); // RQ6
  property p_valid_cmd;
    @(posedge CLK) disable iff (!NRST)
    cmd_bus.valid |-> cmd_bus.cmd == cmd_q;
  endproperty
  a_valid_cmd: assert property (p_valid_cmd) else $error("command code mixed"); // RQ22
  property p_skip_silent;
    @(posedge CLK) disable iff (!NRST)
    state_q == NVW_SKIP |-> SDA_OE_N;
  endproperty
  a_skip_silent: assert property (p_skip_silent) else $error("ack while ignoring"); // RQ25
  property p_idle_stays;
    @(posedge CLK) disable iff (!NRST)
    (state_q == NVW_IDLE && !start_det) |=> state_q == NVW_IDLE;
  endproperty
  a_idle_stays: assert property (p_idle_stays) else $error("left idle without start"); // RQ10
  property p_start_release;
    @(posedge CLK) disable iff (!NRST)
    start_det |=> SDA_OE_N;
  endproperty
  a_start_release: assert property (p_start_release) else $error("drive after start"); // RQ11
  property p_stop_release;
    @(posedge CLK) disable iff (!NRST)
    stop_det |=> SDA_OE_N;
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("drive after stop"); // RQ12
endmodule // nvw_top
`default_nettype wire

// ---- rtl/nvw_map.svh ----
// Constants for the wiper serial slave: address, commands, timing.
// Assumes inclusion by bare name from files under rtl/.
`ifndef NVW_MAP_SVH
`define NVW_MAP_SVH
`define NVW_ADDR_TOP 4'h5
`define NVW_CMD_LIVE 8'h11
`define NVW_CMD_STORE 8'h21
`define NVW_CMD_COPY_SL 8'h61
`define NVW_CMD_COPY_LS 8'h51
`define NVW_STORED_RESET 5'h00
`define NVW_CLK_MHZ 50
`define NVW_STORE_MS 12
`define NVW_INIT_US 20
`define NVW_STORE_CYC (`NVW_STORE_MS * 1000 * `NVW_CLK_MHZ)
`define NVW_INIT_CYC (`NVW_INIT_US * `NVW_CLK_MHZ)
`define NVW_WIPER_W 5
`endif

// ---- rtl/nvw_pkg.sv ----
// Types shared by the wiper serial slave modules.
// Assumes nvw_map.svh is reachable on the include path.
`include "nvw_map.svh"
package nvw_pkg;
  typedef logic [`NVW_WIPER_W-1:0] nvw_wiper_type;
  typedef enum logic [2:0] {
    NVW_IDLE = 3'h0,
    NVW_ADDR = 3'h1,
    NVW_CMD = 3'h3,
    NVW_DATA = 3'h2,
    NVW_SKIP = 3'h6
  } nvw_state_type;
endpackage

// ---- rtl/nvw_cmd_if.sv ----
// Carrier for one decoded write between the serial front end and the wiper store.
// Assumes a single clock domain on both ends.
`timescale 1ns/1ps
`default_nettype none
interface nvw_cmd_if;
  import nvw_pkg::*;
  logic valid;
  logic [7:0] cmd;
  nvw_wiper_type data;
  modport src (output valid, output cmd, output data);
  modport dst (input valid, input cmd, input data);
endinterface
`default_nettype wire

// ---- rtl/nvw_sync.sv ----
// Two-stage synchroniser for pin inputs.
// Assumes the input is asynchronous to CLK.
`timescale 1ns/1ps
`default_nettype none
module nvw_sync (
  input wire logic clk, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic din, // Asynchronous input
  output logic dout // Synchronised level
);
  logic meta_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // nvw_sync
`default_nettype wire

// ---- rtl/nvw_store.sv ----
// Wiper registers: live and stored, power-up recall, store busy timer.
// Assumes commands arrive as one-cycle valid pulses from the serial end.
`timescale 1ns/1ps
`default_nettype none
`include "nvw_map.svh"
module nvw_store #(
  parameter int STORE_CYC = `NVW_STORE_CYC,
  parameter int INIT_CYC = `NVW_INIT_CYC
) (
  input wire logic clk, // Clock
  input wire logic nrst, // Reset, active low
  nvw_cmd_if.dst cmd_in, // Decoded write
  output nvw_pkg::nvw_wiper_type wiper, // Live wiper position
  output nvw_pkg::nvw_wiper_type stored, // Stored position
  output logic busy, // Store programming in progress
  output logic init_done // Power-up recall finished
);
  import nvw_pkg::*;
  nvw_wiper_type live_q;
  // Stored value not reset by NRST: in silicon it survives power loss
  nvw_wiper_type nv_q = `NVW_STORED_RESET; // RQ23
  logic [23:0] busy_cnt_q;
  logic [15:0] init_cnt_q;
  logic init_q;
  wire is_live = cmd_in.valid && init_q && cmd_in.cmd == `NVW_CMD_LIVE;
  wire is_store = cmd_in.valid && init_q && cmd_in.cmd == `NVW_CMD_STORE;
  wire is_sl = cmd_in.valid && init_q && cmd_in.cmd == `NVW_CMD_COPY_SL;
  wire is_ls = cmd_in.valid && init_q && cmd_in.cmd == `NVW_CMD_COPY_LS;
  wire init_end = !init_q && init_cnt_q == 16'(INIT_CYC - 1);
  // Live register clears with power; stored register models retained storage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      live_q <= '0; // RQ4
      init_q <= 1'b0;
      init_cnt_q <= '0;
    end else begin
      if (!init_q) init_cnt_q <= init_cnt_q + 16'h0001; // RQ24
      if (init_end) begin
        init_q <= 1'b1;
        live_q <= nv_q; // RQ5
      end else if (is_live) live_q <= cmd_in.data; // RQ2
      else if (is_sl) live_q <= nv_q; // RQ22
    end
  end
  always_ff @(posedge clk) begin
    if (is_store) nv_q <= cmd_in.data; // RQ2
    else if (is_ls) nv_q <= live_q; // RQ22
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) busy_cnt_q <= '0;
    else if (is_store || is_ls) busy_cnt_q <= 24'(STORE_CYC); // RQ3
    else if (busy_cnt_q != 24'h000000) busy_cnt_q <= busy_cnt_q - 24'h000001;
  end
  assign wiper = live_q; // RQ1
  assign stored = nv_q;
  assign busy = busy_cnt_q != 24'h000000;
  assign init_done = init_q;
  // Helper for the recall bound: cycles since reset, saturating at the budget
  logic [15:0] since_rst_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) since_rst_q <= '0;
    else if (since_rst_q != 16'(INIT_CYC)) since_rst_q <= since_rst_q + 16'h0001;
  end
  property p_init_load;
    @(posedge clk) disable iff (!nrst)
    init_end |=> wiper == $past(nv_q);
  endproperty
  a_init_load: assert property (p_init_load) else $error("recall missed"); // RQ5
  property p_live;
    @(posedge clk) disable iff (!nrst)
    is_live |=> wiper == $past(cmd_in.data);
  endproperty
  a_live: assert property (p_live) else $error("live write missed"); // RQ2
  property p_store_nomove;
    @(posedge clk) disable iff (!nrst)
    is_store |=> $stable(wiper);
  endproperty
  a_store_nomove: assert property (p_store_nomove) else $error("store moved wiper"); // RQ2
  property p_busy;
    @(posedge clk) disable iff (!nrst)
    (is_store || is_ls) |=> busy [*8];
  endproperty
  a_busy: assert property (p_busy) else $error("busy too short"); // RQ3
  property p_init_bound;
    @(posedge clk) disable iff (!nrst)
    since_rst_q == 16'(INIT_CYC) |-> init_done;
  endproperty
  a_init_bound: assert property (p_init_bound) else $error("init late"); // RQ24
endmodule // nvw_store
`default_nettype wire

// ---- bench/nvw_master.sv ----
// Two-wire bus master model for the wiper slave: makes the serial clock, sends frames.
// Assumes a pull-up on the data line, resolved by the bench from both pull-downs.
`timescale 1ns/1ps
`default_nettype none
module nvw_master (
  output logic scl, // Serial clock, owned by the master
  output logic sda_pull_n, // Low while the master pulls data low
  input wire logic sda // Resolved data line level
);
  localparam int LOW_NS = 60; // Two low halves plus the high time give 160 ns
  localparam int HIGH_NS = 40;
  initial begin
    scl = 1'b1;
    sda_pull_n = 1'b1;
  end
  // Ack must be low right after the rise and just before the fall
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_pull_n <= b[i];
      #LOW_NS scl <= 1'b1;
      #HIGH_NS scl <= 1'b0;
      #LOW_NS;
    end
    sda_pull_n <= 1'b1;
    #LOW_NS scl <= 1'b1;
    #5 ack = ~sda;
    #(HIGH_NS - 10) ack = ack & ~sda;
    #5 scl <= 1'b0;
    #LOW_NS;
  endtask
  task automatic xfer(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d,
                      output logic [2:0] ack);
    #200 sda_pull_n <= 1'b0;
    #LOW_NS scl <= 1'b0;
    #LOW_NS;
    put_byte(a, ack[2]);
    put_byte(c, ack[1]);
    put_byte(d, ack[0]);
    sda_pull_n <= 1'b0;
    #LOW_NS scl <= 1'b1;
    #LOW_NS sda_pull_n <= 1'b1;
    #LOW_NS;
  endtask
endmodule // nvw_master
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the wiper slave, with a reference model of both registers.
// Assumes the master model in nvw_master.sv and shortened store and recall counts.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import nvw_pkg::*;
  localparam int STORE_N = 50;
  localparam int INIT_N = 20;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sel = 1'b0;
  wire logic scl;
  wire logic sda_pull_n;
  logic sda_o;
  logic sda_oe_n;
  nvw_wiper_type wiper;
  nvw_wiper_type stored;
  logic busy;
  logic init_done;
  int n_errors = 0;
  int n_tests = 0;
  int seed = 32'hDA516A35;
  int live_m = 0;
  int stored_m = 0;
  int run_len = 0;
  int busy_len = 0;
  logic [7:0] cmds [4] = '{8'h11, 8'h21, 8'h61, 8'h51};
  logic [6:0] me;
  // Pull-up: the line is low only while some party pulls it
  wire logic sda = (!sda_pull_n || (!sda_oe_n && !sda_o)) ? 1'b0 : 1'b1;
  always #10 clk = ~clk;
  nvw_master m (.scl(scl), .sda_pull_n(sda_pull_n), .sda(sda));
  nvw_top #(.STORE_CYC(STORE_N), .INIT_CYC(INIT_N)) uut (.CLK(clk), .NRST(nrst),
    .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n),
    .ADDRESS_SELECT_PIN(sel), .WIPER(wiper), .STORED(stored), .BUSY(busy),
    .INIT_DONE(init_done));
  // Length of the last busy run, in sampled cycles
  always @(posedge clk) begin
    if (busy === 1'b1) run_len <= run_len + 1;
    else if (run_len != 0) begin
      busy_len <= run_len;
      run_len <= 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (n_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic do_reset;
    int k;
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    check({3'h0, wiper}, 8'h00);
    nrst <= 1'b1;
    for (k = 0; k < 100 && init_done !== 1'b1; k++) @(posedge clk);
    check(8'((k >= INIT_N - 2) && (k <= INIT_N + 3)), 8'h01);
    repeat (2) @(posedge clk);
    // Recall puts the retained position back on the wiper
    live_m = stored_m;
    check({3'h0, wiper}, 8'(live_m));
    check({3'h0, stored}, 8'(stored_m));
  endtask
  task automatic run(input logic [6:0] a7, input logic rw, input logic [7:0] cmd,
                     input logic [4:0] pos);
    logic [2:0] ack;
    logic [7:0] r;
    bit hit;
    r = 8'($random(seed));
    hit = (a7 == me) && !rw;
    m.xfer({a7, rw}, cmd, {pos, r[2:0]}, ack);
    check({7'h0, ack[2]}, 8'(a7 == me));
    if (a7 == me) check({6'h0, ack[1:0]}, 8'h03);
    if (hit) begin
      case (cmd)
        8'h11: live_m = pos;
        8'h21: stored_m = pos;
        8'h61: live_m = stored_m;
        8'h51: stored_m = live_m;
        default: ;
      endcase
    end
    if (hit && (cmd == 8'h21 || cmd == 8'h51)) begin
      for (int k = 0; k < 200 && busy !== 1'b0; k++) @(posedge clk);
      repeat (2) @(posedge clk);
      check(8'(busy_len), 8'(STORE_N));
    end
    repeat (6) @(posedge clk);
    check({3'h0, wiper}, 8'(live_m));
    check({3'h0, stored}, 8'(stored_m));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #1ms;
    n_errors++;
    close_out;
  end
  initial begin
    do_reset;
    for (int s = 0; s < 2; s++) begin
      sel <= s[0];
      @(posedge clk);
      me = {4'h5, 2'b00, sel};
      foreach (cmds[i]) run(me, 1'b0, cmds[i], 5'($random(seed)));
    end
    run(me, 1'b0, 8'h11, 5'h1F);
    run(me, 1'b0, 8'h11, 5'h00);
    run(me, 1'b0, 8'h21, 5'h1F);
    run({me[6:1], ~me[0]}, 1'b0, 8'h11, 5'h0A);
    run({4'h6, me[2:0]}, 1'b0, 8'h21, 5'h05);
    run(me, 1'b1, 8'h11, 5'h0C);
    run(me, 1'b0, 8'h31, 5'h07);
    run(me, 1'b0, 8'h11, 5'h03);
    do_reset;
    for (int i = 0; i < 6; i++) run(me, 1'b0, cmds[$unsigned($random(seed)) % 4],
                                    5'($random(seed)));
    close_out;
  end
endmodule // testbench
`default_nettype wire
